// ===== bfps_pkg.sv
// constants and types for the buck fault protection sequencer
package bfps_pkg;
    localparam int NCH = 4;
    localparam int DIV_W = 2;
    localparam int CLK_MHZ = 100;
    localparam int US_PER_MS = 1000;
    localparam int SS_SHORT_MS = 2;
    localparam int SS_LONG_MS = 16;
    localparam int PG_DELAY_US = 50;
    localparam int SS_SHORT_CYC = SS_SHORT_MS * US_PER_MS * CLK_MHZ;
    localparam int SS_LONG_CYC = SS_LONG_MS * US_PER_MS * CLK_MHZ;
    localparam int PG_DELAY_CYC = PG_DELAY_US * CLK_MHZ;
    localparam int TMR_W = 21;
    localparam int PGC_W = 16;
    // fault counter trips on the event after it has reached 15
    localparam logic [3:0] OC_LIMIT = 4'hF;
    localparam logic [3:0] OC_STEP = 4'h1;
    // seven soft-start units off, and latch on the seventh failed retry
    localparam logic [2:0] HICCUP_LAST = 3'h6;
    localparam logic [2:0] RETRY_LAST = 3'h6;
    localparam logic [2:0] CNT3_STEP = 3'h1;
    localparam logic [1:0] PH_FIRST = 2'h0;
    localparam logic [1:0] PH_MID = 2'h1;
    localparam logic [1:0] PH_LAST = 2'h2;
    localparam logic [1:0] PH_STEP = 2'h1;
    localparam logic [1:0] DIV_ONE = 2'h0;
    localparam logic [1:0] DIV_HALF = 2'h1;
    localparam logic [1:0] DIV_QUARTER = 2'h2;
    localparam logic [1:0] SENSE_FLOAT = 2'h0;
    localparam logic [1:0] SENSE_47K = 2'h1;
    localparam logic [1:0] SENSE_22K = 2'h2;
    localparam logic [1:0] ILIM_6A9 = 2'h0;
    localparam logic [1:0] ILIM_3A8 = 2'h1;
    localparam logic [1:0] ILIM_10A4 = 2'h2;

    typedef enum logic [2:0] {
        CH_OFF,
        CH_SOFT,
        CH_RUN,
        CH_HICCUP,
        CH_LATCH
    } bfps_chst_t;

    typedef struct packed {
        logic [NCH-1:0] en;
        logic [NCH-1:0] fbh;
        logic [NCH-1:0] fbq;
        logic [NCH-1:0] ssa;
        logic [NCH-1:0] pk;
        logic [NCH-1:0] ng;
        logic [NCH-1:0] mxd;
        logic [NCH-1:0] byd;
        logic [NCH-1:0] uvl;
        logic [NCH-1:0] uvh;
        logic [NCH-1:0] pgo;
        logic [NCH-1:0] pgb;
        logic thi;
        logic tlo;
    } bfps_in_t;

    typedef struct packed {
        bfps_in_t s1;
        bfps_in_t s2;
        bfps_chst_t [NCH-1:0] st;
        logic [NCH-1:0][TMR_W-1:0] tmr;
        logic [NCH-1:0][3:0] ocn;
        logic [NCH-1:0][2:0] rty;
        logic [NCH-1:0][2:0] hic;
        logic [NCH-1:0][1:0] ph;
        logic [NCH-1:0] init;
        logic [NCH-1:0] hold;
        logic [NCH-1:0] skip;
        logic [NCH-1:0] ssp;
        logic [NCH-1:0] pkd;
        logic [NCH-1:0] uv;
        logic overtemperature_shutdown;
        logic [PGC_W-1:0] pgc;
        logic pg;
        logic [1:0] ilm1;
        logic [1:0] ilm2;
    } bfps_state_t;
endpackage

// ===== bfps_top.sv
// per-channel protection and sequencing for a four-channel buck
// Operation
// - parallel pair: second phase follows first
// - block reverse current until reference passes feedback
// - peak limit: high off, low on
// - three peak limit levels from sensing
// - negative limit ends low-side conduction
// - feedback below half halves frequency
// - feedback below quarter quarters frequency
// - max duty skips every second pulse
// - beyond max duty skips two of three
// - fault counter overflow past 15 stops switching
// - hiccup seven soft-starts, then retry
// - no hiccup detection in initial soft-start
// - fuse disables hiccup, foldback stays active
// - latch off after seven failed retries
// - latch cleared by re-enable or supply loss
// - no latch-off while hiccup disabled
// - supply lockout at 3.79, restart above 4.22
// - channel one lockout stops all channels
// - good flag above 90.5 percent, selectable
// - flag drops after 50 us below 87.2
// - overtemperature stops all, restarts soft-start
// - soft-start 2 or 16 ms per pair
`timescale 1ns/10ps
module bfps_top #(
    parameter int SS_SHORT_CYCLES = bfps_pkg::SS_SHORT_CYC,
    parameter int SS_LONG_CYCLES = bfps_pkg::SS_LONG_CYC,
    parameter int PG_DELAY_CYCLES = bfps_pkg::PG_DELAY_CYC
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic [bfps_pkg::NCH-1:0] CHANNEL_ENABLE_PIN,
    input wire logic [bfps_pkg::NCH-1:0] FB_BELOW_HALF,
    input wire logic [bfps_pkg::NCH-1:0] FB_BELOW_QUARTER,
    input wire logic [bfps_pkg::NCH-1:0] SS_ABOVE_FB,
    input wire logic [bfps_pkg::NCH-1:0] PEAK_LIMIT,
    input wire logic [bfps_pkg::NCH-1:0] NEG_LIMIT,
    input wire logic [bfps_pkg::NCH-1:0] MAX_DUTY,
    input wire logic [bfps_pkg::NCH-1:0] BEYOND_MAX_DUTY,
    input wire logic [bfps_pkg::NCH-1:0] SUPPLY_BELOW_OFF,
    input wire logic [bfps_pkg::NCH-1:0] SUPPLY_ABOVE_ON,
    input wire logic [bfps_pkg::NCH-1:0] OUT_ABOVE_GOOD,
    input wire logic [bfps_pkg::NCH-1:0] OUT_BELOW_BAD,
    input wire logic TEMP_ABOVE_TRIP,
    input wire logic TEMP_BELOW_CLEAR,
    input wire logic [bfps_pkg::NCH-1:0] CYCLE_START,
    input wire logic PAIR_A_PARALLEL,
    input wire logic PAIR_B_PARALLEL,
    input wire logic PAIR_A_LONG_SS,
    input wire logic PAIR_B_LONG_SS,
    input wire logic [bfps_pkg::NCH-1:0] FUSE_HICCUP_OFF,
    input wire logic [bfps_pkg::NCH-1:0] FUSE_LATCH_OFF,
    input wire logic [bfps_pkg::NCH-1:0] FUSE_GOOD_SELECT,
    input wire logic [1:0] LOW_SIDE_DRIVE_ONE_SENSE,
    input wire logic [1:0] LOW_SIDE_DRIVE_TWO_SENSE,
    output logic [bfps_pkg::NCH-1:0] HS_ALLOW,
    output logic [bfps_pkg::NCH-1:0] LS_ALLOW,
    output logic [bfps_pkg::NCH-1:0] LS_FORCE,
    output logic [bfps_pkg::NCH*bfps_pkg::DIV_W-1:0] FREQ_DIVIDE,
    output logic [bfps_pkg::NCH-1:0] SOFT_START_TRIGGER,
    output logic [bfps_pkg::NCH-1:0] LATCHED_OFF,
    output logic [1:0] PEAK_LEVEL_ONE,
    output logic [1:0] PEAK_LEVEL_TWO,
    output logic [1:0] PHASE_FOLLOW,
    output logic OUTPUT_GOOD_FLAG_O,
    output logic OUTPUT_GOOD_FLAG_OE,
    output logic OVERTEMPERATURE_SHUTDOWN
);
    import bfps_pkg::*;

    localparam logic [PGC_W-1:0] PG_LIM = PGC_W'(PG_DELAY_CYCLES);

    bfps_state_t r;
    bfps_state_t n;
    bfps_in_t raw;
    logic [NCH-1:0] en_e;
    logic [NCH-1:0] fbh_e;
    logic [NCH-1:0] fbq_e;
    logic [NCH-1:0] ssa_e;
    logic [NCH-1:0] pk_ev;
    logic [NCH-1:0] in_soft;

    function automatic logic pair_par(input int c);
        return (c < NCH / 2) ? PAIR_A_PARALLEL : PAIR_B_PARALLEL;
    endfunction

    // the second phase of a paralleled pair borrows the first's enable, feedback and soft-start inputs
    function automatic int src_ch(input int c);
        return (pair_par(c) && c % 2 == 1) ? c - 1 : c;
    endfunction

    function automatic logic [TMR_W-1:0] ss_last(input int c);
        logic lng;
        lng = (c < NCH / 2) ? PAIR_A_LONG_SS : PAIR_B_LONG_SS;
        return lng ? TMR_W'(SS_LONG_CYCLES - 1)
                   : TMR_W'(SS_SHORT_CYCLES - 1);
    endfunction

    function automatic logic [1:0] ilim_pick(input logic [1:0] sense);
        case (sense)
            SENSE_47K: return ILIM_3A8;
            SENSE_22K: return ILIM_10A4;
            default: return ILIM_6A9;
        endcase
    endfunction

    assign raw = '{en: CHANNEL_ENABLE_PIN, fbh: FB_BELOW_HALF,
        fbq: FB_BELOW_QUARTER, ssa: SS_ABOVE_FB, pk: PEAK_LIMIT,
        ng: NEG_LIMIT, mxd: MAX_DUTY, byd: BEYOND_MAX_DUTY,
        uvl: SUPPLY_BELOW_OFF, uvh: SUPPLY_ABOVE_ON,
        pgo: OUT_ABOVE_GOOD, pgb: OUT_BELOW_BAD,
        thi: TEMP_ABOVE_TRIP, tlo: TEMP_BELOW_CLEAR};

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            en_e[c] = r.s2.en[src_ch(c)];
            fbh_e[c] = r.s2.fbh[src_ch(c)];
            fbq_e[c] = r.s2.fbq[src_ch(c)];
            ssa_e[c] = r.s2.ssa[src_ch(c)];
            in_soft[c] = r.st[c] == CH_SOFT;
        end
    end

    assign pk_ev = r.s2.pk & ~r.pkd;

    always_comb begin
        logic trip;
        logic masked;
        trip = 1'b0;
        masked = 1'b0;
        n = r;
        n.s1 = raw;
        n.s2 = r.s1;
        n.ilm1 = ilim_pick(LOW_SIDE_DRIVE_ONE_SENSE);
        n.ilm2 = ilim_pick(LOW_SIDE_DRIVE_TWO_SENSE);
        if (r.s2.thi) begin
            n.overtemperature_shutdown = 1'b1;
        end else if (r.s2.tlo) begin
            n.overtemperature_shutdown = 1'b0;
        end
        for (int c = 0; c < NCH; c++) begin
            if (r.s2.uvl[c]) begin
                n.uv[c] = 1'b1;
            end else if (r.s2.uvh[c]) begin
                n.uv[c] = 1'b0;
            end
            n.pkd[c] = r.s2.pk[c];
            n.ssp[c] = 1'b0;
            // a new limit event wins over the cycle start clearing it
            n.hold[c] = r.s2.pk[c] | (r.hold[c] & ~CYCLE_START[c]);
            if (CYCLE_START[c]) begin
                if (r.s2.byd[c]) begin
                    n.ph[c] = (r.ph[c] == PH_LAST) ? PH_FIRST
                                                   : r.ph[c] + PH_STEP;
                end else if (r.s2.mxd[c]) begin
                    n.ph[c] = (r.ph[c] == PH_FIRST) ? PH_MID : PH_FIRST;
                end else begin
                    n.ph[c] = PH_FIRST;
                end
                n.skip[c] = n.ph[c] != PH_FIRST;
            end
            if (pk_ev[c] && r.ocn[c] != OC_LIMIT) begin
                n.ocn[c] = r.ocn[c] + OC_STEP;
            end
            masked = in_soft[c] & r.init[c];
            trip = pk_ev[c] && r.ocn[c] == OC_LIMIT
                   && !FUSE_HICCUP_OFF[c] && !masked;
            case (r.st[c])
                CH_OFF: begin
                    n.ocn[c] = '0;
                    n.rty[c] = '0;
                    n.hic[c] = '0;
                    trip = 1'b0;
                    if (en_e[c] && !r.uv[c] && !r.uv[0] && !r.overtemperature_shutdown) begin
                        n.st[c] = CH_SOFT;
                        n.tmr[c] = '0;
                        n.init[c] = 1'b1;
                        n.ssp[c] = 1'b1;
                    end
                end
                CH_SOFT: begin
                    n.tmr[c] = r.tmr[c] + TMR_W'(1);
                    if (!trip && r.tmr[c] == ss_last(c)) begin
                        n.st[c] = CH_RUN;
                        n.ocn[c] = '0;
                        n.rty[c] = '0;
                    end
                end
                CH_RUN: begin
                end
                CH_HICCUP: begin
                    trip = 1'b0;
                    n.tmr[c] = r.tmr[c] + TMR_W'(1);
                    if (r.tmr[c] == ss_last(c)) begin
                        n.tmr[c] = '0;
                        n.hic[c] = r.hic[c] + CNT3_STEP;
                        if (r.hic[c] == HICCUP_LAST) begin
                            n.st[c] = CH_SOFT;
                            n.hic[c] = '0;
                            n.ocn[c] = '0;
                            n.init[c] = 1'b0;
                            n.ssp[c] = 1'b1;
                        end
                    end
                end
                CH_LATCH: begin
                    trip = 1'b0;
                end
                default: begin
                    trip = 1'b0;
                    n.st[c] = CH_OFF;
                end
            endcase
            if (trip) begin
                n.tmr[c] = '0;
                n.hic[c] = '0;
                n.ocn[c] = '0;
                n.st[c] = CH_HICCUP;
                // the latch needs hiccup detection to count failures at all
                if (FUSE_LATCH_OFF[c] && !r.init[c]) begin
                    if (r.rty[c] == RETRY_LAST) begin
                        n.st[c] = CH_LATCH;
                    end else begin
                        n.rty[c] = r.rty[c] + CNT3_STEP;
                    end
                end
            end
            if (!en_e[c] || r.uv[c]) begin
                n.st[c] = CH_OFF;
            end else if ((r.overtemperature_shutdown || r.uv[0]) && r.st[c] != CH_LATCH) begin
                n.st[c] = CH_OFF;
            end
        end
        // any monitored output low for the whole delay clears the flag
        if ((FUSE_GOOD_SELECT & r.s2.pgb) != '0) begin
            if (r.pgc < PG_LIM) begin
                n.pgc = r.pgc + PGC_W'(1);
            end else begin
                n.pg = 1'b0;
            end
        end else begin
            n.pgc = '0;
            if (FUSE_GOOD_SELECT != '0
                && (FUSE_GOOD_SELECT & ~r.s2.pgo) == '0) begin
                n.pg = 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    always_comb begin
        logic act;
        act = 1'b0;
        for (int c = 0; c < NCH; c++) begin
            act = r.st[c] == CH_SOFT || r.st[c] == CH_RUN;
            HS_ALLOW[c] = act & ~r.hold[c] & ~r.skip[c];
            // reverse current stays blocked while the output is precharged
            LS_ALLOW[c] = act & ~r.s2.ng[c]
                          & ~(in_soft[c] & ~ssa_e[c]);
            LS_FORCE[c] = act & r.hold[c] & ~r.s2.ng[c];
            if (fbq_e[c]) begin
                FREQ_DIVIDE[DIV_W*c +: DIV_W] = DIV_QUARTER;
            end else if (fbh_e[c]) begin
                FREQ_DIVIDE[DIV_W*c +: DIV_W] = DIV_HALF;
            end else begin
                FREQ_DIVIDE[DIV_W*c +: DIV_W] = DIV_ONE;
            end
            LATCHED_OFF[c] = r.st[c] == CH_LATCH;
        end
    end

    assign SOFT_START_TRIGGER = r.ssp;
    assign PEAK_LEVEL_ONE = r.ilm1;
    assign PEAK_LEVEL_TWO = r.ilm2;
    assign PHASE_FOLLOW = {PAIR_B_PARALLEL, PAIR_A_PARALLEL};
    assign OUTPUT_GOOD_FLAG_O = 1'b0;
    assign OUTPUT_GOOD_FLAG_OE = ~r.pg;
    assign OVERTEMPERATURE_SHUTDOWN = r.overtemperature_shutdown;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    pair_follow_a: assert property (PAIR_A_PARALLEL |->
        en_e[1] == r.s2.en[0] && fbh_e[1] == r.s2.fbh[0])
        else $error("second phase not following first");
    precharge_block_a: assert property (
        (LS_ALLOW & in_soft & ~ssa_e) == '0)
        else $error("low side allowed into precharged output");
    peak_hold_a: assert property (
        $rose(r.s2.pk[0]) |=> !HS_ALLOW[0])
        else $error("high side on after peak limit");
    neg_limit_a: assert property (r.s2.ng[0] |->
        !LS_ALLOW[0] && !LS_FORCE[0])
        else $error("low side on at negative limit");
    fold_quarter_a: assert property (
        fbq_e[0] |-> FREQ_DIVIDE[DIV_W-1:0] == DIV_QUARTER)
        else $error("no quarter foldback");
    skip_half_a: assert property (r.s2.mxd[0] && !r.s2.byd[0]
        && CYCLE_START[0] && r.skip[0] |=> !r.skip[0])
        else $error("max duty skip not alternating");
    skip_third_a: assert property (r.s2.byd[0]
        && CYCLE_START[0] && !r.skip[0] |=> r.skip[0])
        else $error("beyond max duty skip missing");
    oc_trip_a: assert property (r.st[0] == CH_RUN && pk_ev[0]
        && r.ocn[0] == OC_LIMIT && !FUSE_HICCUP_OFF[0]
        |=> r.st[0] != CH_RUN ##1 !HS_ALLOW[0] && !LS_ALLOW[0])
        else $error("overflow did not stop switching");
    init_mask_a: assert property (in_soft[0] && r.init[0]
        |=> r.st[0] != CH_HICCUP)
        else $error("hiccup during initial soft start");
    no_latch_a: assert property (FUSE_HICCUP_OFF[0]
        && r.st[0] != CH_LATCH |=> r.st[0] != CH_LATCH)
        else $error("latch with hiccup disabled");
    uv_one_a: assert property (r.uv[0] |=> HS_ALLOW == '0)
        else $error("channel runs in primary lockout");
    good_delay_a: assert property ($fell(r.pg) |->
        $past(r.pgc) == PG_LIM)
        else $error("good flag dropped early");
    thermal_off_a: assert property (r.overtemperature_shutdown |=>
        HS_ALLOW == '0 && LS_ALLOW == '0)
        else $error("switching during overtemperature");
endmodule

// ===== bfps_stage_model.sv
// power stage and current comparator model facing the sequencer
`timescale 1ns/10ps
module bfps_stage_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [bfps_pkg::NCH-1:0] hs_allow,
    input wire logic [bfps_pkg::NCH-1:0] short_on,
    output logic [bfps_pkg::NCH-1:0] cycle_start,
    output logic [bfps_pkg::NCH-1:0] peak_limit
);
    import bfps_pkg::*;
    logic [2:0] cnt_r;
    // one switching cycle is eight clocks, shared by every phase
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 3'h0;
            cycle_start <= '0;
            peak_limit <= '0;
        end else begin
            cnt_r <= cnt_r + 3'h1;
            cycle_start <= {NCH{cnt_r == 3'h7}};
            // a shorted output only reaches the limit while the high side
            // conducts, so a gated channel raises no further events
            peak_limit <= (cnt_r == 3'h2) ? (short_on & hs_allow) : '0;
        end
    end
endmodule

// ===== bfps_top_test.sv
// self-checking bench for the buck fault protection sequencer
`timescale 1ns/10ps
module bfps_top_test;
    import bfps_pkg::*;
    localparam int SS = 200;
    localparam int SL = 280;
    localparam int PG = 10;
    logic clk, rst_n, t_hi, t_lo, pa, pb, pg_o, pg_oe, ot;
    logic [3:0] en, fbh, fbq, ssa, ng, mxd, byd, uvl, uvh, pgo, pgb;
    logic [3:0] hof, lof, sel, shrt, cs, pk, hs, ls, lsf, sst, lat;
    logic [1:0] sn1, sn2, pl1, pl2, fol;
    logic [7:0] fdiv;
    logic [1:0] lv [3] = '{ILIM_6A9, ILIM_3A8, ILIM_10A4};
    logic [1:0] sc [3] = '{SENSE_FLOAT, SENSE_47K, SENSE_22K};
    int err_total = 0;
    int check_count = 0;
    int n, k;
    bfps_top #(.SS_SHORT_CYCLES(SS), .SS_LONG_CYCLES(SL),
            .PG_DELAY_CYCLES(PG)) dut_u (
        .CLOCK(clk), .RST_N(rst_n), .CHANNEL_ENABLE_PIN(en),
        .FB_BELOW_HALF(fbh), .FB_BELOW_QUARTER(fbq), .SS_ABOVE_FB(ssa),
        .PEAK_LIMIT(pk), .NEG_LIMIT(ng), .MAX_DUTY(mxd),
        .BEYOND_MAX_DUTY(byd), .SUPPLY_BELOW_OFF(uvl),
        .SUPPLY_ABOVE_ON(uvh), .OUT_ABOVE_GOOD(pgo), .OUT_BELOW_BAD(pgb),
        .TEMP_ABOVE_TRIP(t_hi), .TEMP_BELOW_CLEAR(t_lo), .CYCLE_START(cs),
        .PAIR_A_PARALLEL(pa), .PAIR_B_PARALLEL(pb),
        .PAIR_A_LONG_SS(1'h0), .PAIR_B_LONG_SS(1'h1),
        .FUSE_HICCUP_OFF(hof), .FUSE_LATCH_OFF(lof), .FUSE_GOOD_SELECT(sel),
        .LOW_SIDE_DRIVE_ONE_SENSE(sn1), .LOW_SIDE_DRIVE_TWO_SENSE(sn2),
        .HS_ALLOW(hs), .LS_ALLOW(ls), .LS_FORCE(lsf), .FREQ_DIVIDE(fdiv),
        .SOFT_START_TRIGGER(sst), .LATCHED_OFF(lat), .PEAK_LEVEL_ONE(pl1),
        .PEAK_LEVEL_TWO(pl2), .PHASE_FOLLOW(fol), .OUTPUT_GOOD_FLAG_O(pg_o),
        .OUTPUT_GOOD_FLAG_OE(pg_oe), .OVERTEMPERATURE_SHUTDOWN(ot));
    bfps_stage_model pm_u (.clock(clk), .rst_n(rst_n), .hs_allow(hs),
        .short_on(shrt), .cycle_start(cs), .peak_limit(pk));

    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic tick(int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    function automatic logic pick(int s, int ch);
        case (s)
            0: return sst[ch];
            1: return ls[ch];
            2: return lsf[ch];
            3: return pg_oe;
            default: return cs[ch];
        endcase
    endfunction

    // counts clocks until the chosen output reaches the level
    task automatic wait_on(int s, int ch, logic lvl, int lim, output int c);
        c = 0;
        do begin
            tick(1);
            c++;
        end while (pick(s, ch) !== lvl && c < lim);
        if (pick(s, ch) !== lvl) begin
            err_total++;
            $display("wait ran out on signal %0d", s);
            close_out();
        end
    endtask

    initial begin
        {en, fbh, fbq, ng, mxd, byd, uvl, pgo, shrt, t_hi, pa, pb} = '0;
        {sn1, sn2} = 4'h0;
        {uvh, pgb, ssa} = 12'hFFE;
        {hof, lof, sel} = 12'h8C1;
        t_lo = 1;
        rst_n = 0;
        tick(8);
        rst_n = 1;
        chk("gates at reset", {hs, ls, lsf}, 12'h000);
        chk("flag at reset", {pg_oe, pg_o, ot, lat}, 7'h40);
        for (int i = 0; i < 3; i++) begin
            sn1 = sc[i];
            sn2 = sc[2 - i];
            tick(3);
            chk("peak one", pl1, lv[i]);
            chk("peak two", pl2, lv[2 - i]);
        end
        $display("test limits done");
        en[0] = 1;
        wait_on(0, 0, 1, 10, n);
        chk("start delay", n, 3);
        chk("precharged gates", {hs[0], ls[0]}, 2'h2);
        ssa[0] = 1;
        tick(3);
        chk("reverse allowed", ls[0], 1);
        fbh[0] = 1;
        tick(3);
        chk("fold half", fdiv[1:0], DIV_HALF);
        fbq[0] = 1;
        tick(3);
        chk("fold quarter", fdiv[1:0], DIV_QUARTER);
        {fbh[0], fbq[0], ng[0]} = 3'h1;
        tick(3);
        chk("fold off", fdiv[1:0], DIV_ONE);
        chk("negative limit", ls[0], 0);
        ng[0] = 0;
        tick(SS);
        for (int m = 0; m < 2; m++) begin
            {byd[0], mxd[0]} = m ? 2'h3 : 2'h1;
            tick(24);
            k = 0;
            repeat (12) begin
                wait_on(4, 0, 1, 10, n);
                tick(4);
                k += (hs[0] === 1'h1);
            end
            chk("pulses kept", k, m ? 4 : 6);
        end
        {byd[0], mxd[0]} = 2'h0;
        $display("test start and foldback done");
        shrt[0] = 1;
        k = 0;
        for (n = 0; n < 400 && ls[0] === 1'h1; n++) begin
            k += (pk[0] === 1'h1);
            tick(1);
        end
        if (n == 400) begin
            err_total++;
            $display("wait ran out in trip loop");
            close_out();
        end
        chk("events to trip", k, 16);
        chk("trip gates", {hs[0], ls[0]}, 2'h0);
        wait_on(0, 0, 1, 2000, n);
        chk("hiccup span", n >= 7 * SS - 3 && n <= 7 * SS + 3, 1);
        wait_on(1, 0, 0, 400, n);
        chk("retry trips", hs[0], 0);
        shrt[0] = 0;
        wait_on(0, 0, 1, 2000, n);
        tick(SS + 20);
        chk("recovered", {hs[0], ls[0]}, 2'h3);
        {shrt[1], en[1]} = 2'h3;
        wait_on(0, 1, 1, 10, n);
        wait_on(2, 1, 1, 20, n);
        chk("peak cuts high side", hs[1], 0);
        wait_on(2, 1, 0, 20, n);
        chk("next cycle restores", hs[1], 1);
        tick(SS - 40);
        chk("start not tripped", ls[1], 1);
        {shrt[1], en[1]} = 2'h0;
        $display("test hiccup done");
        {shrt[3:2], en[3:2]} = 4'hF;
        // the low side is already off before the start, so see it start first
        wait_on(0, 2, 1, 10, n);
        wait_on(1, 2, 0, 3000, n);
        wait_on(0, 2, 1, 3000, n);
        chk("long span", n >= 7 * SL - 3 && n <= 7 * SL + 3, 1);
        k = 0;
        for (n = 0; n < 20000 && lat[2] !== 1'h1; n++) begin
            tick(1);
            k += (sst[2] === 1'h1);
        end
        if (n == 20000) begin
            err_total++;
            $display("wait ran out in latch loop");
            close_out();
        end
        chk("retries to latch", k, 6);
        chk("latched gates", {hs[2], ls[2]}, 2'h0);
        chk("hiccup fuse off", {lat[3], ls[3]}, 2'h1);
        fbh[3] = 1;
        tick(3);
        chk("fold kept", fdiv[7:6], DIV_HALF);
        {shrt[3:2], fbh[3], en[2]} = 4'h0;
        tick(4);
        chk("latch cleared", lat[2], 0);
        en[3:2] = 2'h1;
        $display("test latch done");
        {pgo[0], pgb[0]} = 2'h2;
        wait_on(3, 0, 0, 6, n);
        chk("good rise", n, 3);
        {pgo[0], pgb[0]} = 2'h1;
        tick(PG - 3);
        {pgo[0], pgb[0]} = 2'h2;
        k = 0;
        repeat (8) begin
            k += (pg_oe !== 1'h0);
            tick(1);
        end
        chk("short dip", k, 0);
        {pgo[0], pgb[0]} = 2'h1;
        wait_on(3, 0, 1, 40, n);
        chk("good fall", n >= PG + 2 && n <= PG + 4, 1);
        {sel, pgo, pgb} = 12'h220;
        wait_on(3, 0, 0, 6, n);
        chk("other channel", n, 3);
        $display("test flag done");
        {pa, pb} = 2'h3;
        sn2 = sn1;
        // own enables low: second phases start from the first's enable
        {en[3], en[1]} = 2'h0;
        k = 0;
        repeat (6) begin
            tick(1);
            k += (sst[1] === 1'h1) + (sst[3] === 1'h1);
        end
        chk("follow", fol, 2'h3);
        chk("second enable", k, 2);
        en[1] = 0;
        tick(3);
        {pa, pb} = 2'h0;
        {uvl[0], uvh[0]} = 2'h2;
        tick(4);
        chk("lockout all", {hs[2:0], ls[2:0]}, 6'h00);
        {uvl[0], uvh[0]} = 2'h1;
        wait_on(0, 0, 1, 10, n);
        chk("supply restart", n <= 4, 1);
        {t_hi, t_lo} = 2'h2;
        tick(4);
        chk("hot", {ot, hs[2:0], ls[2:0]}, 7'h40);
        {t_hi, t_lo} = 2'h1;
        wait_on(0, 0, 1, 10, n);
        chk("cool restart", {ot, sst[2:0]}, 4'h5);
        $display("test supply and heat done");
        close_out();
    end
endmodule
